// ==== core/nv_down_counter.sv ====
/*
  Loadable down counter with a done flag, used for the long host-side waits.
  Assumes the same clock and synchronous reset as the controller.
*/
`timescale 1ns/1ps
module nv_down_counter #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] count_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (load_i) begin
      count_r <= value_i;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b1;
    end else begin
      done_o <= !load_i && (count_r <= W'(1));
    end
  end
endmodule

// ==== core/nv_host_ctrl.sv ====
/*
  Host controller for a nonvolatile static RAM: plain byte reads and writes,
  six-read command sequences, and hardware store requests on the busy pin.
  Assumes the memory strobes are wired straight to the ports and that the
  busy pin has an external pull-up.
*/
`timescale 1ns/1ps
module nv_host_ctrl #(
  parameter int STORE_WAIT = nv_host_pkg::STORE_CYCLES,
  parameter int HW_DELAY_WAIT = nv_host_pkg::HW_DELAY_CYCLES,
  parameter int SEQ_PROC_WAIT = nv_host_pkg::SEQ_PROC_CYCLES,
  parameter int RECALL_WAIT = nv_host_pkg::RECALL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [16:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic hw_store_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic mem_ce_n_o,
  output logic mem_oe_n_o,
  output logic mem_we_n_o,
  output logic [16:0] mem_addr_o,
  output logic [7:0] data_io_o,
  output logic data_io_oe_o,
  input wire logic [7:0] data_io_i,
  output logic hw_store_req_busy_n_o,
  output logic hw_store_req_busy_n_oe_o,
  input wire logic hw_store_req_busy_n_i,
  output logic busy_seen_o
);
  typedef enum {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_NEXT, ST_HW_PULSE, ST_WAIT
  } state_e;

  state_e state_r;
  logic [2:0] step_r;
  logic seq_r;
  logic write_r;
  logic [1:0] op_r;
  logic [nv_host_pkg::TIMER_W-1:0] short_r;
  logic busy_m_r;
  logic busy_s_r;
  logic [7:0] data_m_r;
  logic [7:0] data_s_r;
  logic tmr_load;
  logic [nv_host_pkg::TIMER_W-1:0] tmr_value;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_m_r <= 1'b1;
      busy_s_r <= 1'b1;
      data_m_r <= 8'h00;
      data_s_r <= 8'h00;
    end else begin
      busy_m_r <= hw_store_req_busy_n_i;
      busy_s_r <= busy_m_r;
      data_m_r <= data_io_i;
      data_s_r <= data_m_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_seen_o <= 1'b0;
    end else begin
      busy_seen_o <= !busy_s_r;
    end
  end

  // ----------------------------------------------------------------
  // Long waits
  // ----------------------------------------------------------------
  nv_down_counter #(
    .W(nv_host_pkg::TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_value),
    .done_o(tmr_done)
  );

  function automatic logic [16:0] seq_addr(input logic [2:0] step, input logic [1:0] op);
    logic [16:0] a;
    a = nv_host_pkg::SEQ_ADDR0;
    case (step)
      3'h0: a = nv_host_pkg::SEQ_ADDR0;
      3'h1: a = nv_host_pkg::SEQ_ADDR1;
      3'h2: a = nv_host_pkg::SEQ_ADDR2;
      3'h3: a = nv_host_pkg::SEQ_ADDR3;
      3'h4: a = nv_host_pkg::SEQ_ADDR4;
      default: begin
        case (op)
          nv_host_pkg::OP_STORE: a = nv_host_pkg::CMD_STORE;
          nv_host_pkg::OP_RECALL: a = nv_host_pkg::CMD_RECALL;
          nv_host_pkg::OP_AUTO_OFF: a = nv_host_pkg::CMD_AUTO_OFF;
          default: a = nv_host_pkg::CMD_AUTO_ON;
        endcase
      end
    endcase
    return a;
  endfunction

  function automatic logic [nv_host_pkg::TIMER_W-1:0] op_wait(input logic [1:0] op);
    logic [nv_host_pkg::TIMER_W-1:0] w;
    // Mode commands only need the processing time; store and recall add lockout.
    w = nv_host_pkg::TIMER_W'(SEQ_PROC_WAIT);
    case (op)
      nv_host_pkg::OP_STORE: w = nv_host_pkg::TIMER_W'(SEQ_PROC_WAIT + STORE_WAIT);
      nv_host_pkg::OP_RECALL: w = nv_host_pkg::TIMER_W'(SEQ_PROC_WAIT + RECALL_WAIT);
      default: w = nv_host_pkg::TIMER_W'(SEQ_PROC_WAIT);
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Timer control
  // ----------------------------------------------------------------
  always_comb begin
    tmr_load = 1'b0;
    tmr_value = '0;
    if (state_r == ST_NEXT && seq_r && step_r == 3'h5) begin
      tmr_load = 1'b1;
      tmr_value = op_wait(op_r);
    end else if (state_r == ST_HW_PULSE && short_r == '0) begin
      // Grace delay plus a full store; the device may skip the store, the host cannot tell.
      tmr_load = 1'b1;
      tmr_value = nv_host_pkg::TIMER_W'(HW_DELAY_WAIT + STORE_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      step_r <= 3'h0;
      seq_r <= 1'b0;
      write_r <= 1'b0;
      op_r <= nv_host_pkg::OP_STORE;
      short_r <= '0;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      mem_ce_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_addr_o <= 17'h00000;
      data_io_o <= 8'h00;
      data_io_oe_o <= 1'b0;
      hw_store_req_busy_n_o <= 1'b1;
      hw_store_req_busy_n_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          ready_o <= busy_s_r;
          // A low busy pin blocks new accesses until it rises again.
          if (busy_s_r && ready_o) begin
            if (hw_store_i) begin
              ready_o <= 1'b0;
              hw_store_req_busy_n_o <= 1'b0;
              hw_store_req_busy_n_oe_o <= 1'b1;
              short_r <= nv_host_pkg::TIMER_W'(nv_host_pkg::PULSE_CYCLES);
              state_r <= ST_HW_PULSE;
            end else if (cmd_valid_i) begin
              ready_o <= 1'b0;
              seq_r <= 1'b1;
              write_r <= 1'b0;
              op_r <= cmd_op_i;
              step_r <= 3'h0;
              mem_addr_o <= seq_addr(3'h0, cmd_op_i);
              state_r <= ST_SETUP;
            end else if (req_valid_i) begin
              ready_o <= 1'b0;
              seq_r <= 1'b0;
              write_r <= req_write_i;
              mem_addr_o <= req_addr_i;
              data_io_o <= req_wdata_i;
              data_io_oe_o <= req_write_i;
              state_r <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // Address is stable one cycle before the strobes fall.
          mem_ce_n_o <= 1'b0;
          mem_oe_n_o <= write_r;
          mem_we_n_o <= !write_r;
          short_r <= nv_host_pkg::TIMER_W'(nv_host_pkg::STROBE_CYCLES);
          state_r <= ST_STROBE;
        end
        ST_STROBE: begin
          if (short_r == '0) begin
            rdata_o <= data_s_r;
            mem_ce_n_o <= 1'b1;
            mem_oe_n_o <= 1'b1;
            mem_we_n_o <= 1'b1;
            short_r <= nv_host_pkg::TIMER_W'(nv_host_pkg::READ_CYCLES - nv_host_pkg::STROBE_CYCLES);
            state_r <= ST_GAP;
          end else begin
            short_r <= short_r - nv_host_pkg::TIMER_W'(1);
          end
        end
        ST_GAP: begin
          data_io_oe_o <= 1'b0;
          if (short_r == '0) begin
            state_r <= ST_NEXT;
          end else begin
            short_r <= short_r - nv_host_pkg::TIMER_W'(1);
          end
        end
        ST_NEXT: begin
          if (seq_r && step_r != 3'h5) begin
            // Each read of the sequence is a full read cycle apart.
            step_r <= step_r + 3'h1;
            mem_addr_o <= seq_addr(step_r + 3'h1, op_r);
            state_r <= ST_SETUP;
          end else if (seq_r) begin
            state_r <= ST_WAIT;
          end else begin
            done_o <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_HW_PULSE: begin
          if (short_r == '0) begin
            hw_store_req_busy_n_o <= 1'b1;
            hw_store_req_busy_n_oe_o <= 1'b0;
            state_r <= ST_WAIT;
          end else begin
            short_r <= short_r - nv_host_pkg::TIMER_W'(1);
          end
        end
        ST_WAIT: begin
          // The host waits the full worst-case time, since a skipped store cannot be told apart.
          if (tmr_done) begin
            seq_r <= 1'b0;
            done_o <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== include/nv_host_pkg.sv ====
/*
  Constants shared by the host controller of a nonvolatile static RAM:
  command sequence addresses, timing figures and derived cycle counts.
  Assumes a 100 MHz host clock.
*/
package nv_host_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CMP_W = 16;
  localparam logic [16:0] SEQ_ADDR0 = 17'h04e38;
  localparam logic [16:0] SEQ_ADDR1 = 17'h0b1c7;
  localparam logic [16:0] SEQ_ADDR2 = 17'h083e0;
  localparam logic [16:0] SEQ_ADDR3 = 17'h07c1f;
  localparam logic [16:0] SEQ_ADDR4 = 17'h0703f;
  localparam logic [16:0] CMD_STORE = 17'h08fc0;
  localparam logic [16:0] CMD_RECALL = 17'h04c63;
  localparam logic [16:0] CMD_AUTO_OFF = 17'h08b45;
  localparam logic [16:0] CMD_AUTO_ON = 17'h04b46;
  localparam logic [1:0] OP_STORE = 2'h0;
  localparam logic [1:0] OP_RECALL = 2'h1;
  localparam logic [1:0] OP_AUTO_OFF = 2'h2;
  localparam logic [1:0] OP_AUTO_ON = 2'h3;
  // Read cycle time of the slowest speed grade, in ns.
  localparam int READ_CYCLE_NS = 45;
  localparam int STROBE_LOW_NS = 30;
  localparam int STORE_PULSE_NS = 15;
  localparam int SEQ_PROC_US = 70;
  localparam int HW_DELAY_US = 70;
  localparam int STORE_MAX_MS = 15;
  localparam int RECALL_MAX_US = 50;
  // Least times round up, waits for the device use plain division and round down.
  localparam int READ_CYCLES = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYCLES = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYCLES = (STORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEQ_PROC_CYCLES = SEQ_PROC_US * 1000000 / CLK_PERIOD_PS;
  localparam int HW_DELAY_CYCLES = HW_DELAY_US * 1000000 / CLK_PERIOD_PS;
  // Divide first: milliseconds times picoseconds does not fit in a 32-bit int.
  localparam int STORE_CYCLES = STORE_MAX_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int RECALL_CYCLES = RECALL_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int TIMER_W = 24;
endpackage

// ==== verif/nv_host_ctrl_sva.sv ====
/*
  Checker for the nonvolatile RAM host controller: strobe shapes, sequences.
  Assumes it is bound to nv_host_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module nv_host_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic cmd_valid_i,
  input wire logic hw_store_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_oe_n_o,
  input wire logic mem_we_n_o,
  input wire logic [16:0] mem_addr_o,
  input wire logic data_io_oe_o,
  input wire logic hw_store_req_busy_n_o,
  input wire logic hw_store_req_busy_n_oe_o
);
  logic in_cmd_r;
  logic oe_q_r;
  logic [2:0] falls_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    oe_q_r <= mem_oe_n_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || done_o) in_cmd_r <= 1'b0;
    else if (ready_o && cmd_valid_i && !hw_store_i) in_cmd_r <= 1'b1;
  end
  // Counts read strobes of one command so a short or long sequence shows up.
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_cmd_r) falls_r <= 3'h0;
    else if (oe_q_r && !mem_oe_n_o) falls_r <= falls_r + 3'h1;
  end
  sequence read_take;
    ready_o && req_valid_i && !cmd_valid_i && !hw_store_i;
  endsequence
  sequence oe_fall;
    oe_q_r && !mem_oe_n_o;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> mem_ce_n_o && mem_oe_n_o && mem_we_n_o && !ready_o)
    else $error("strobes not idle after reset");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  read_shape_a: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_ce_n_o && !data_io_oe_o)
    else $error("bad read strobes");
  write_shape_a: assert property (!mem_we_n_o |-> mem_oe_n_o && !mem_ce_n_o && data_io_oe_o)
    else $error("bad write strobes");
  addr_hold_a: assert property ($past(!mem_ce_n_o) && !mem_ce_n_o |-> $stable(mem_addr_o))
    else $error("address moved under strobe");
  strobe_width_a: assert property (oe_fall |-> !mem_oe_n_o [*3])
    else $error("read strobe too short");
  read_done_a: assert property (read_take |=> ##[0:14] done_o) else $error("read never done");
  cmd_six_a: assert property (in_cmd_r && done_o |-> falls_r == 3'h6)
    else $error("command without six reads");
  seq_first_a: assert property (in_cmd_r && falls_r == 3'h0 && oe_q_r && !mem_oe_n_o |->
    mem_addr_o == nv_host_pkg::SEQ_ADDR0) else $error("wrong first sequence address");
  cmd_no_write_a: assert property (in_cmd_r |-> mem_we_n_o) else $error("write inside command");
  hw_pulse_a: assert property ($rose(hw_store_req_busy_n_oe_o) |->
    (hw_store_req_busy_n_oe_o && !hw_store_req_busy_n_o) [*2]) else $error("store request too short");
endmodule
bind nv_host_ctrl nv_host_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .cmd_valid_i(cmd_valid_i), .hw_store_i(hw_store_i), .ready_o(ready_o), .done_o(done_o),
  .mem_ce_n_o(mem_ce_n_o), .mem_oe_n_o(mem_oe_n_o), .mem_we_n_o(mem_we_n_o), .mem_addr_o(mem_addr_o),
  .data_io_oe_o(data_io_oe_o), .hw_store_req_busy_n_o(hw_store_req_busy_n_o),
  .hw_store_req_busy_n_oe_o(hw_store_req_busy_n_oe_o));

// ==== verif/nv_sram_model.sv ====
/*
  Behavioural nonvolatile static RAM with command tracker and busy pin.
  Assumes the bench resolves the pulled-up busy pin and the data bus.
*/
`timescale 1ns/1ps
module nv_sram_model #(
  parameter int STORE_NS = 300,
  parameter int RECALL_NS = 150,
  parameter int HW_NS = 100
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic busy_pin_i,
  output logic busy_drv_o = 1'b0,
  output logic [7:0] store_cnt_o = 8'h00,
  output logic [7:0] recall_cnt_o = 8'h00,
  output logic auto_en_o = 1'b1,
  output logic [7:0] bad_o = 8'h00
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] nv [logic [16:0]];
  logic [15:0] seq [5] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
  logic [7:0] rd_val = 8'h00;
  logic lock = 1'b0;
  logic written = 1'b0;
  logic wr_act = 1'b0;
  int step = 0;
  realtime t_rd = 0;
  realtime t_hw = -1000;
  event ev_store;
  event ev_recall;
  wire rd_n = ce_n_i | oe_n_i | ~we_n_i | ~busy_pin_i;
  wire wr_n = ce_n_i | we_n_i;
  // Undriven data shows the inverse so a stale sample cannot pass.
  assign data_oe_o = ~rd_n & ~lock;
  assign data_o = data_oe_o ? rd_val : ~rd_val;
  always @(negedge rd_n) begin
    rd_val = mem.exists(addr_i) ? mem[addr_i] : 8'h00;
    if (lock) bad_o = bad_o + 8'h01;
    else begin
      if (step > 0 && $realtime - t_rd < 45) bad_o = bad_o + 8'h01;
      t_rd = $realtime;
      if (step == 5) begin
        step = 0;
        case (addr_i[15:0])
          nv_host_pkg::CMD_STORE[15:0]: -> ev_store;
          nv_host_pkg::CMD_RECALL[15:0]: -> ev_recall;
          nv_host_pkg::CMD_AUTO_OFF[15:0]: auto_en_o = 1'b0;
          nv_host_pkg::CMD_AUTO_ON[15:0]: auto_en_o = 1'b1;
          default: step = 0;
        endcase
      end else if (addr_i[15:0] == seq[step]) step = step + 1;
      else step = (addr_i[15:0] == seq[0]) ? 1 : 0;
    end
  end
  always @(negedge wr_n) begin
    step = 0;
    wr_act = 1'b1;
    if (lock) bad_o = bad_o + 8'h01;
  end
  // Only a real low pulse is a write; the step from unknown to high at start-up is not.
  always @(posedge wr_n) if (wr_act) begin
    wr_act = 1'b0;
    if (!lock && busy_pin_i === 1'b1) begin
      mem[addr_i] = data_i;
      written = 1'b1;
    end
  end
  always @(ev_store) begin
    busy_drv_o = 1'b1;
    lock = 1'b1;
    #(STORE_NS);
    nv = mem;
    written = 1'b0;
    store_cnt_o = store_cnt_o + 8'h01;
    lock = 1'b0;
    busy_drv_o = 1'b0;
  end
  always @(ev_recall) begin
    lock = 1'b1;
    #(RECALL_NS);
    mem = nv;
    written = 1'b0;
    recall_cnt_o = recall_cnt_o + 8'h01;
    lock = 1'b0;
  end
  always @(negedge busy_pin_i) if (!busy_drv_o) begin
    t_hw = $realtime;
    #(HW_NS);
    if (written) -> ev_store;
  end
  always @(posedge busy_pin_i) if (!busy_drv_o && $realtime - t_hw < 15) bad_o = bad_o + 8'h01;
endmodule

// ==== verif/nv_store_recall_sequencer_tb.sv ====
/*
  Self-checking bench: host controller against the behavioural RAM model.
  Assumes shortened waits on the controller and a pulled-up busy pin.
*/
`timescale 1ns/1ps
module nv_store_recall_sequencer_tb;
  typedef struct {logic wr; logic [16:0] a; logic [7:0] d;} row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [16:0] req_addr_i = 17'h00000;
  logic [7:0] req_wdata_i = 8'h00;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0;
  logic hw_store_i = 1'b0;
  logic ready_o, done_o, ce_n, oe_n, we_n, dq_oe, hw_o, hw_oe, busy_seen_o, ram_oe, drv, auto_en;
  logic [7:0] rdata_o, dq_o, ram_q, n_store, n_recall, bad;
  logic [16:0] addr;
  logic seen_busy = 1'b0;
  int errors = 0;
  int n_checks = 0;
  wire [7:0] dq = dq_oe ? dq_o : ram_q;
  wire busy_pin = ~((hw_oe & ~hw_o) | drv);
  row_s rows [6] = '{'{1'b1, 17'h00012, 8'ha5}, '{1'b1, 17'h1ffff, 8'h3c}, '{1'b1, 17'h0ffff, 8'h77},
    '{1'b0, 17'h00012, 8'ha5}, '{1'b0, 17'h1ffff, 8'h3c}, '{1'b0, 17'h0ffff, 8'h77}};
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (busy_seen_o === 1'b1) seen_busy <= 1'b1;
  nv_host_ctrl #(.STORE_WAIT(50), .HW_DELAY_WAIT(20), .SEQ_PROC_WAIT(20), .RECALL_WAIT(10)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .hw_store_i(hw_store_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .mem_ce_n_o(ce_n),
    .mem_oe_n_o(oe_n), .mem_we_n_o(we_n), .mem_addr_o(addr), .data_io_o(dq_o), .data_io_oe_o(dq_oe),
    .data_io_i(dq), .hw_store_req_busy_n_o(hw_o), .hw_store_req_busy_n_oe_o(hw_oe),
    .hw_store_req_busy_n_i(busy_pin), .busy_seen_o(busy_seen_o));
  nv_sram_model u_ram (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .data_i(dq),
    .data_o(ram_q), .data_oe_o(ram_oe), .busy_pin_i(busy_pin), .busy_drv_o(drv), .store_cnt_o(n_store),
    .recall_cnt_o(n_recall), .auto_en_o(auto_en), .bad_o(bad));
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  // Kind 0 is a byte access, 1 a command (op in a), 2 a hardware store.
  task automatic run(input int kind, input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid_i <= (kind == 0);
    cmd_valid_i <= (kind == 1);
    hw_store_i <= (kind == 2);
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    cmd_op_i <= a[1:0];
    do begin @(posedge clk_i); n++; end while (ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    cmd_valid_i <= 1'b0;
    hw_store_i <= 1'b0;
    do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && n < 2000);
    chk(n < 2000, "operation never done");
  endtask
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      run(0, rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rdata_o === rows[i].d, "read data");
    end
    seen_busy = 1'b0;
    run(1, 1'b0, 17'h0, 8'h00);
    chk(n_store === 8'h01 && seen_busy === 1'b1, "software store");
    run(0, 1'b1, 17'h00012, 8'h22);
    run(1, 1'b0, 17'h1, 8'h00);
    run(0, 1'b0, 17'h00012, 8'h00);
    chk(n_recall === 8'h01 && rdata_o === 8'ha5, "recall data");
    run(2, 1'b0, 17'h0, 8'h00);
    chk(n_store === 8'h01, "store without write");
    run(0, 1'b1, 17'h00012, 8'h5a);
    run(2, 1'b0, 17'h0, 8'h00);
    chk(n_store === 8'h02, "hardware store");
    for (int op = 2; op < 4; op++) begin
      run(1, 1'b0, 17'(op), 8'h00);
      chk(auto_en === op[0], "automatic store mode");
    end
    req_valid_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b1;
    req_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(ce_n === 1'b1 && ready_o === 1'b0, "reset in mid read");
    run(0, 1'b0, 17'h1ffff, 8'h00);
    chk(rdata_o === 8'h3c, "read after reset");
    chk(bad === 8'h00, "illegal access at memory");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    summarize();
  end
endmodule
